// file: design/rvt_consts.vh
`ifndef RVT_CONSTS_VH
`define RVT_CONSTS_VH

// Register indices; byte address is four times the index
`define RVT_IDX_TX_TEST_MODE    10'h00D
`define RVT_IDX_BIAS_OVR_VAL    10'h3CC
`define RVT_IDX_OVR_EN          10'h3CD
`define RVT_IDX_CAL_CFG         10'h3D0
`define RVT_IDX_XTAL_CFG        10'h3D2
`define RVT_IDX_BAND_RESULT     10'h3DA
`define RVT_IDX_BIAS_RESULT     10'h3DB
`define RVT_IDX_PROBE_SEL       10'h3F8
`define RVT_IDX_PROBE_MUX       10'h3F9
`define RVT_IDX_PIN_FUNC        10'h3FA
`define RVT_IDX_DAC_GAIN        10'h3FD

// Reset values
`define RVT_RST_TX_TEST_MODE    8'h00
`define RVT_RST_BIAS_OVR_VAL    8'h00
`define RVT_RST_OVR_EN          8'h00
`define RVT_RST_CAL_CFG         8'h01
`define RVT_RST_XTAL_CFG        8'h00
`define RVT_RST_RESULT          8'h00
`define RVT_RST_PROBE_SEL       8'h00
`define RVT_RST_PROBE_MUX       8'h00
`define RVT_RST_PIN_FUNC        8'h00
`define RVT_RST_DAC_GAIN        8'h04

// Field positions
`define RVT_BAND_OVR_EN_BIT     0
`define RVT_BIAS_OVR_EN_BIT     1
`define RVT_QREF_LSB            2
`define RVT_QREF_MSB            5
`define RVT_CAL_CFG_MSB         3
`define RVT_XTAL_LSB            3
`define RVT_XTAL_MSB            5
`define RVT_PROBE_MUX_MSB       1
`define RVT_DAC_GAIN_MSB        3

// Field values
`define RVT_CAL_BYPASS          4'hF
`define RVT_CAL_ENABLE          4'h1
`define RVT_PROBE_SEL_RSSI      8'h64
`define RVT_PROBE_MUX_RSSI      2'h3

// Pin function codes
`define RVT_PF_SLICER           8'h21
`define RVT_PF_LIMITER          8'h40
`define RVT_PF_LIMITER_FILT     8'h41
`define RVT_PF_PKT_TX           8'h50
`define RVT_PF_PA_RAMP          8'h53
`define RVT_PF_SPORT_FIRST      8'hA0
`define RVT_PF_SPORT_LAST       8'hA8
`define RVT_PF_TEST_DAC         8'hC9

// Transmit test modes
`define RVT_TXM_NORMAL          8'h00
`define RVT_TXM_RANDOM          8'h01
`define RVT_TXM_PREAMBLE        8'h02
`define RVT_TXM_CARRIER         8'h03

`endif

// file: design/rvt_regs.v
// Summary of operation
// - Bias override replaces calibrated value when enabled.
// - Enable bit 1 gates bias override, reset 0.
// - Enable bit 0 gates band override, reset 0.
// - Enable bits 5:2 hold quadrature amplitude reference.
// - Calibration config 0xF skips calibration.
// - Config 0x1 calibrates on each tx/rx entry.
// - Crystal tuning word in bits 5:3.
// - Two read-only calibration results, reset zero.
// - Code 0x21 puts slicer on pin five.
// - Code 0x40 puts limiters on pins 0, 1.
// - Code 0x41 filtered and unfiltered limiter outputs.
// - Code 0x50 puts packet transmit data on pin 0.
// - Code 0x53 shows amplifier ramp done on pin 0.
// - Code 0xC9 puts test converter on pin 0.
// - Test mode 0 normal; 4-255 reserved.
// - Test mode 1 sends random data continuously.
// - Test mode 2 sends preamble continuously.
// - Test mode 3 sends carrier continuously.
// - Band override replaces calibrated band when enabled.
`include "rvt_consts.vh"
`default_nettype none

module rvt_regs #(
    parameter DW = 8
) (
    input  wire          clock,
    input  wire          rst_n,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    input  wire [DW-1:0] cal_band_value,
    input  wire [DW-1:0] cal_bias_value,
    input  wire          cal_done,
    input  wire          enter_tx_rx,
    input  wire [DW-1:0] osc_band_override_value,
    input  wire          slicer_out,
    input  wire          lim_q,
    input  wire          lim_i,
    input  wire          lim_q_filt,
    input  wire          lim_i_filt,
    input  wire          pkt_tx_data,
    input  wire          pa_ramp_done,
    input  wire          test_dac_bit,
    input  wire          dflt_gp0,
    input  wire          dflt_gp1,
    input  wire          dflt_gp2,
    input  wire          dflt_irq,
    input  wire          dflt_gp5,
    output reg  [DW-1:0] osc_band_dac_q,
    output reg  [DW-1:0] osc_bias_dac_q,
    output reg  [3:0]    quad_phase_amplitude_ref_q,
    output reg  [2:0]    crystal_tuning_word_q,
    output reg           cal_start_q,
    output reg  [DW-1:0] probe_select_q,
    output reg  [1:0]    probe_mux_q,
    output reg           analog_probe_rssi_q,
    output reg  [3:0]    test_dac_gain_q,
    output reg           sport_en_q,
    output reg  [3:0]    sport_mode_q,
    output reg           tx_random_q,
    output reg           tx_preamble_q,
    output reg           tx_carrier_q,
    output reg           general_pin_zero_q,
    output reg           general_pin_one_q,
    output reg           general_pin_two_q,
    output reg           interrupt_general_pin_q,
    output reg           general_pin_five_q
);

    // Software-visible storage
    reg [DW-1:0] tx_mode_q;
    reg [DW-1:0] bias_ovr_q;
    reg [DW-1:0] ovr_en_q;
    reg [DW-1:0] cal_cfg_q;
    reg [DW-1:0] xtal_cfg_q;
    reg [DW-1:0] band_res_q;
    reg [DW-1:0] bias_res_q;
    reg [DW-1:0] probe_sel_q;
    reg [DW-1:0] probe_mx_q;
    reg [DW-1:0] pin_func_q;
    reg [DW-1:0] dac_gain_q;

    // Bus decode
    wire [9:0]   idx;
    wire         setup;
    wire         wr_take;
    reg  [DW-1:0] rd_d;
    reg          hit_d;
    wire [DW-1:0] wdat;

    assign idx     = paddr[11:2];
    assign setup   = psel & ~penable;
    assign wr_take = psel & penable & pready & pwrite & ~pslverr;
    assign wdat    = pwdata[DW-1:0];

    // Read mux and address map check
    always @* begin
        rd_d  = {DW{1'b0}};
        hit_d = 1'b1;
        if (paddr[1:0] != 2'b00) begin
            hit_d = 1'b0;
        end else begin
            case (idx)
                `RVT_IDX_TX_TEST_MODE: rd_d = tx_mode_q;
                `RVT_IDX_BIAS_OVR_VAL: rd_d = bias_ovr_q;
                `RVT_IDX_OVR_EN:       rd_d = ovr_en_q;
                `RVT_IDX_CAL_CFG:      rd_d = cal_cfg_q;
                `RVT_IDX_XTAL_CFG:     rd_d = xtal_cfg_q;
                `RVT_IDX_BAND_RESULT:  rd_d = band_res_q;
                `RVT_IDX_BIAS_RESULT:  rd_d = bias_res_q;
                `RVT_IDX_PROBE_SEL:    rd_d = probe_sel_q;
                `RVT_IDX_PROBE_MUX:    rd_d = probe_mx_q;
                `RVT_IDX_PIN_FUNC:     rd_d = pin_func_q;
                `RVT_IDX_DAC_GAIN:     rd_d = dac_gain_q;
                default:               hit_d = 1'b0;
            endcase
        end
    end

    // APB answer: one access cycle, registered response
    always @(posedge clock) begin
        if (!rst_n) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (setup) begin
            pready  <= 1'b1;
            pslverr <= ~hit_d;
            prdata  <= (pwrite | ~hit_d) ? 32'h00000000 : {{(32-DW){1'b0}}, rd_d};
        end else begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Writable registers, full width kept
    always @(posedge clock) begin
        if (!rst_n) begin
            tx_mode_q   <= `RVT_RST_TX_TEST_MODE;
            bias_ovr_q  <= `RVT_RST_BIAS_OVR_VAL;
            ovr_en_q    <= `RVT_RST_OVR_EN;
            cal_cfg_q   <= `RVT_RST_CAL_CFG;
            xtal_cfg_q  <= `RVT_RST_XTAL_CFG;
            probe_sel_q <= `RVT_RST_PROBE_SEL;
            probe_mx_q  <= `RVT_RST_PROBE_MUX;
            pin_func_q  <= `RVT_RST_PIN_FUNC;
            dac_gain_q  <= `RVT_RST_DAC_GAIN;
        end else if (wr_take) begin
            case (idx)
                `RVT_IDX_TX_TEST_MODE: tx_mode_q   <= wdat;
                `RVT_IDX_BIAS_OVR_VAL: bias_ovr_q  <= wdat;
                `RVT_IDX_OVR_EN:       ovr_en_q    <= wdat;
                `RVT_IDX_CAL_CFG:      cal_cfg_q   <= wdat;
                `RVT_IDX_XTAL_CFG:     xtal_cfg_q  <= wdat;
                `RVT_IDX_PROBE_SEL:    probe_sel_q <= wdat;
                `RVT_IDX_PROBE_MUX:    probe_mx_q  <= wdat;
                `RVT_IDX_PIN_FUNC:     pin_func_q  <= wdat;
                `RVT_IDX_DAC_GAIN:     dac_gain_q  <= wdat;
                default:               tx_mode_q   <= tx_mode_q;
            endcase
        end
    end

    // Calibration results captured from the calibrator
    always @(posedge clock) begin
        if (!rst_n) begin
            band_res_q <= `RVT_RST_RESULT;
            bias_res_q <= `RVT_RST_RESULT;
        end else if (cal_done) begin
            band_res_q <= cal_band_value;
            bias_res_q <= cal_bias_value;
        end
    end

    // Oscillator controls with override selection
    always @(posedge clock) begin
        if (!rst_n) begin
            osc_band_dac_q             <= {DW{1'b0}};
            osc_bias_dac_q             <= {DW{1'b0}};
            quad_phase_amplitude_ref_q <= 4'h0;
            crystal_tuning_word_q      <= 3'h0;
        end else begin
            osc_band_dac_q <= ovr_en_q[`RVT_BAND_OVR_EN_BIT] ?
                osc_band_override_value : cal_band_value;
            osc_bias_dac_q <= ovr_en_q[`RVT_BIAS_OVR_EN_BIT] ?
                bias_ovr_q : cal_bias_value;
            quad_phase_amplitude_ref_q <=
                ovr_en_q[`RVT_QREF_MSB:`RVT_QREF_LSB];
            crystal_tuning_word_q <=
                xtal_cfg_q[`RVT_XTAL_MSB:`RVT_XTAL_LSB];
        end
    end

    // Calibration request on entry to transmit or receive
    always @(posedge clock) begin
        if (!rst_n) begin
            cal_start_q <= 1'b0;
        end else begin
            cal_start_q <= enter_tx_rx &
                (cal_cfg_q[`RVT_CAL_CFG_MSB:0] != `RVT_CAL_BYPASS);
        end
    end

    // Analog probe and test converter settings
    always @(posedge clock) begin
        if (!rst_n) begin
            probe_select_q      <= {DW{1'b0}};
            probe_mux_q         <= 2'h0;
            analog_probe_rssi_q <= 1'b0;
            test_dac_gain_q     <= 4'h4;
        end else begin
            probe_select_q      <= probe_sel_q;
            probe_mux_q         <= probe_mx_q[`RVT_PROBE_MUX_MSB:0];
            analog_probe_rssi_q <= (probe_sel_q == `RVT_PROBE_SEL_RSSI) &
                (probe_mx_q[`RVT_PROBE_MUX_MSB:0] == `RVT_PROBE_MUX_RSSI);
            test_dac_gain_q     <= dac_gain_q[`RVT_DAC_GAIN_MSB:0];
        end
    end

    // Transmit test mode decode; zero and reserved codes act as normal
    always @(posedge clock) begin
        if (!rst_n) begin
            tx_random_q   <= 1'b0;
            tx_preamble_q <= 1'b0;
            tx_carrier_q  <= 1'b0;
        end else begin
            tx_random_q   <= (tx_mode_q == `RVT_TXM_RANDOM);
            tx_preamble_q <= (tx_mode_q == `RVT_TXM_PREAMBLE);
            tx_carrier_q  <= (tx_mode_q == `RVT_TXM_CARRIER);
        end
    end

    // Serial port mode decode
    wire sport_hit;
    wire [DW-1:0] sport_off;
    assign sport_hit = (pin_func_q >= `RVT_PF_SPORT_FIRST) &
                       (pin_func_q <= `RVT_PF_SPORT_LAST);
    assign sport_off = pin_func_q - `RVT_PF_SPORT_FIRST;

    always @(posedge clock) begin
        if (!rst_n) begin
            sport_en_q   <= 1'b0;
            sport_mode_q <= 4'h0;
        end else begin
            sport_en_q   <= sport_hit;
            sport_mode_q <= sport_hit ? sport_off[3:0] : 4'h0;
        end
    end

    // Pin function multiplexer
    reg p0_d;
    reg p1_d;
    reg p2_d;
    reg p3_d;
    reg p5_d;

    always @* begin
        p0_d = dflt_gp0;
        p1_d = dflt_gp1;
        p2_d = dflt_gp2;
        p3_d = dflt_irq;
        p5_d = dflt_gp5;
        case (pin_func_q)
            `RVT_PF_SLICER: begin
                p5_d = slicer_out;
            end
            `RVT_PF_LIMITER: begin
                p0_d = lim_q;
                p1_d = lim_i;
            end
            `RVT_PF_LIMITER_FILT: begin
                p0_d = lim_q_filt;
                p1_d = lim_i_filt;
                p2_d = lim_q;
                p3_d = lim_i;
            end
            `RVT_PF_PKT_TX: begin
                p0_d = pkt_tx_data;
            end
            `RVT_PF_PA_RAMP: begin
                p0_d = pa_ramp_done;
            end
            `RVT_PF_TEST_DAC: begin
                p0_d = test_dac_bit;
            end
            default: begin
                p0_d = dflt_gp0;
            end
        endcase
    end

    // Registered pin drive
    always @(posedge clock) begin
        if (!rst_n) begin
            general_pin_zero_q      <= 1'b0;
            general_pin_one_q       <= 1'b0;
            general_pin_two_q       <= 1'b0;
            interrupt_general_pin_q <= 1'b0;
            general_pin_five_q      <= 1'b0;
        end else begin
            general_pin_zero_q      <= p0_d;
            general_pin_one_q       <= p1_d;
            general_pin_two_q       <= p2_d;
            interrupt_general_pin_q <= p3_d;
            general_pin_five_q      <= p5_d;
        end
    end

endmodule

`default_nettype wire

// file: dv/rvt_regs_chk.sv
`include "rvt_consts.vh"
`default_nettype none
module rvt_regs_chk #(
    parameter DW = 8
) (
    input wire logic          clock,
    input wire logic          rst_n,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic [DW-1:0] cal_band_value,
    input wire logic [DW-1:0] cal_bias_value,
    input wire logic          enter_tx_rx,
    input wire logic [DW-1:0] osc_band_override_value,
    input wire logic          slicer_out,
    input wire logic          dflt_gp5,
    input wire logic [DW-1:0] osc_band_dac_q,
    input wire logic [DW-1:0] osc_bias_dac_q,
    input wire logic [3:0]    quad_phase_amplitude_ref_q,
    input wire logic          cal_start_q,
    input wire logic          general_pin_five_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] en_q;
    logic [7:0] bov_q;
    logic [7:0] pf_q;
    logic [7:0] cc_q;
    logic       wr_ok;
    logic       band_en;
    logic       bias_en;
    logic [3:0] qref;

    // Accepted writes and the shadowed enable fields
    assign wr_ok   = psel & penable & pready & pwrite & ~pslverr;
    assign band_en = en_q[0];
    assign bias_en = en_q[1];
    assign qref    = en_q[5:2];

    // Shadow copies of the calibration, enable, bias override and pin function registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            en_q  <= 8'h00;
            bov_q <= 8'h00;
            pf_q  <= 8'h00;
            cc_q  <= `RVT_RST_CAL_CFG;
        end else if (wr_ok) begin
            if (paddr == {`RVT_IDX_CAL_CFG, 2'b00}) cc_q <= pwdata[7:0];
            if (paddr == {`RVT_IDX_OVR_EN, 2'b00}) en_q <= pwdata[7:0];
            if (paddr == {`RVT_IDX_BIAS_OVR_VAL, 2'b00}) bov_q <= pwdata[7:0];
            if (paddr == {`RVT_IDX_PIN_FUNC, 2'b00}) pf_q <= pwdata[7:0];
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence setup_s; psel && !penable; endsequence
    sequence misaligned_s; psel && !penable && paddr[1:0] != 2'b00; endsequence
    sequence answer_s; pready ##1 !pready; endsequence

    ready_one_cycle_a: assert property (setup_s |=> answer_s)
        else $error("pready not one cycle after setup");
    misaligned_err_a: assert property (misaligned_s |=> pready && pslverr)
        else $error("misaligned access not refused");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    prdata_quiet_a: assert property (!pready || pslverr |-> prdata == 32'h0)
        else $error("prdata not zero outside a good read");
    cal_start_cause_a: assert property (cal_start_q |-> $past(enter_tx_rx))
        else $error("calibration start without state entry");
    cal_bypass_a: assert property ($past(rst_n) |-> cal_start_q ==
        ($past(enter_tx_rx) && $past(cc_q[3:0]) != `RVT_CAL_BYPASS))
        else $error("calibration start does not follow config");
    band_select_a: assert property ($past(rst_n) |-> osc_band_dac_q ==
        ($past(band_en) ? $past(osc_band_override_value) : $past(cal_band_value)))
        else $error("band value source wrong");
    bias_select_a: assert property ($past(rst_n) |-> osc_bias_dac_q ==
        ($past(bias_en) ? $past(bov_q) : $past(cal_bias_value)))
        else $error("bias value source wrong");
    quad_ref_a: assert property ($past(rst_n) |->
        quad_phase_amplitude_ref_q == $past(qref))
        else $error("quadrature reference wrong");
    pin_five_a: assert property ($past(rst_n) |-> general_pin_five_q ==
        ($past(pf_q) == `RVT_PF_SLICER ? $past(slicer_out) : $past(dflt_gp5)))
        else $error("pin five source wrong");
endmodule

bind rvt_regs rvt_regs_chk #(.DW(DW)) u_chk (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cal_band_value(cal_band_value),
    .cal_bias_value(cal_bias_value), .enter_tx_rx(enter_tx_rx),
    .osc_band_override_value(osc_band_override_value), .slicer_out(slicer_out),
    .dflt_gp5(dflt_gp5), .osc_band_dac_q(osc_band_dac_q), .osc_bias_dac_q(osc_bias_dac_q),
    .quad_phase_amplitude_ref_q(quad_phase_amplitude_ref_q), .cal_start_q(cal_start_q),
    .general_pin_five_q(general_pin_five_q));
`default_nettype wire

// file: dv/testbench.sv
`include "rvt_consts.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:0]  cal_band_value = 8'h00, cal_bias_value = 8'h00, band_ovr = 8'h00;
    logic        cal_done = 1'b0, enter_tx_rx = 1'b0;
    logic [12:0] src = 13'h0000;
    logic [7:0]  band_q, bias_q, probe_sel;
    logic [3:0]  qref, gain, smode;
    logic [2:0]  xtal;
    logic [1:0]  pmux;
    logic        cal_start, rssi, sport_en, t_rand, t_pre, t_car, gp0, gp1, gp2, girq, gp5;
    logic [32:0] exp_q[$];
    int          err_count = 0, comparisons = 0;
    logic [9:0]  idx [11] = '{`RVT_IDX_TX_TEST_MODE, `RVT_IDX_BIAS_OVR_VAL, `RVT_IDX_OVR_EN,
        `RVT_IDX_CAL_CFG, `RVT_IDX_XTAL_CFG, `RVT_IDX_BAND_RESULT, `RVT_IDX_BIAS_RESULT,
        `RVT_IDX_PROBE_SEL, `RVT_IDX_PROBE_MUX, `RVT_IDX_PIN_FUNC, `RVT_IDX_DAC_GAIN};
    logic [7:0]  rstv [11] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h04};
    logic [7:0]  codes [9] = '{8'h00, 8'h21, 8'h40, 8'h41, 8'h50, 8'h53, 8'hC9, 8'h7F, 8'hA9};

    rvt_regs #(.DW(8)) uut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cal_band_value(cal_band_value), .cal_bias_value(cal_bias_value),
        .cal_done(cal_done), .enter_tx_rx(enter_tx_rx), .osc_band_override_value(band_ovr),
        .slicer_out(src[12]), .lim_q(src[11]), .lim_i(src[10]), .lim_q_filt(src[9]),
        .lim_i_filt(src[8]), .pkt_tx_data(src[7]), .pa_ramp_done(src[6]),
        .test_dac_bit(src[5]), .dflt_gp0(src[4]), .dflt_gp1(src[3]), .dflt_gp2(src[2]),
        .dflt_irq(src[1]), .dflt_gp5(src[0]), .osc_band_dac_q(band_q), .osc_bias_dac_q(bias_q),
        .quad_phase_amplitude_ref_q(qref), .crystal_tuning_word_q(xtal),
        .cal_start_q(cal_start), .probe_select_q(probe_sel), .probe_mux_q(pmux),
        .analog_probe_rssi_q(rssi), .test_dac_gain_q(gain), .sport_en_q(sport_en),
        .sport_mode_q(smode), .tx_random_q(t_rand), .tx_preamble_q(t_pre), .tx_carrier_q(t_car),
        .general_pin_zero_q(gp0), .general_pin_one_q(gp1), .general_pin_two_q(gp2),
        .interrupt_general_pin_q(girq), .general_pin_five_q(gp5));

    // Free-running clock
    initial forever #5 clock = ~clock;

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the expected response goes to the queue
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input int i, input logic [31:0] d);
        apb(1'b1, {idx[i], 2'b00}, d, 33'h0);
    endtask

    task automatic rd(input int i, input logic [7:0] v);
        apb(1'b0, {idx[i], 2'b00}, 32'h0, {25'h0, v});
    endtask

    // Expected {pin0, pin1, pin2, irq pin, pin5, serial enable}
    function automatic logic [5:0] pins(input logic [7:0] c);
        logic [5:0] p;
        p = {src[4:0], 1'b0};
        case (c)
            `RVT_PF_SLICER:       p[1] = src[12];
            `RVT_PF_LIMITER:      p[5:4] = src[11:10];
            `RVT_PF_LIMITER_FILT: p[5:2] = {src[9:8], src[11:10]};
            `RVT_PF_PKT_TX:       p[5] = src[7];
            `RVT_PF_PA_RAMP:      p[5] = src[6];
            `RVT_PF_TEST_DAC:     p[5] = src[5];
            default:              p[0] = c >= `RVT_PF_SPORT_FIRST && c <= `RVT_PF_SPORT_LAST;
        endcase
        return p;
    endfunction

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Bus responses checked against the oldest note
    always @(posedge clock) begin
        if (rst_n && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("Error at %0t: unexpected response", $time);
            end else
                chk({pslverr, prdata}, exp_q.pop_front());
        end
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (6000) @(posedge clock);
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        report_and_stop;
    end

    // Main sequence
    initial begin
        logic [7:0] v;
        logic [7:0] c;
        logic [5:0] e;
        void'($urandom(77));
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        for (int i = 0; i < 11; i++) rd(i, rstv[i]);
        for (int i = 0; i < 11; i++) begin
            v = 8'($urandom);
            wr(i, {24'($urandom), v});
            rd(i, (i == 5 || i == 6) ? 8'h00 : v);
        end
        apb(1'b0, 12'h004, 32'h0, 33'h1_0000_0000);
        apb(1'b1, {idx[2], 2'b01}, 32'hFF, 33'h1_0000_0000);
        v = 8'($urandom);
        wr(1, {24'h0, v});
        for (int k = 0; k < 4; k++) begin
            c = 8'($urandom);
            cal_band_value <= 8'($urandom);
            cal_bias_value <= 8'($urandom);
            band_ovr <= 8'($urandom);
            wr(2, {24'h0, c[7:2], 2'(k)});
            @(posedge clock);
            chk(33'(band_q), 33'(k[0] ? band_ovr : cal_band_value));
            chk(33'(bias_q), 33'(k[1] ? v : cal_bias_value));
            chk(33'(qref), 33'(c[5:2]));
        end
        cal_band_value <= 8'($urandom);
        cal_bias_value <= 8'($urandom);
        cal_done <= 1'b1;
        @(posedge clock);
        cal_done <= 1'b0;
        rd(5, cal_band_value);
        rd(6, cal_bias_value);
        for (int j = 0; j < 2; j++) begin
            wr(3, j ? 32'h01 : 32'h0F);
            enter_tx_rx <= 1'b1;
            @(posedge clock);
            enter_tx_rx <= 1'b0;
            @(posedge clock);
            chk(33'(cal_start), 33'(j));
            @(posedge clock);
            chk(33'(cal_start), 33'h0);
        end
        v = 8'($urandom);
        wr(4, {24'h0, v});
        wr(7, 32'h64);
        wr(8, 32'h03);
        wr(10, 32'h00);
        @(posedge clock);
        chk(33'(xtal), 33'(v[5:3]));
        chk(33'({rssi, probe_sel, pmux}), 33'({1'b1, 8'h64, 2'h3}));
        chk(33'(gain), 33'h0);
        wr(8, 32'h02);
        @(posedge clock);
        chk(33'(rssi), 33'h0);
        for (int m = 0; m < 5; m++) begin
            c = (m == 4) ? 8'($urandom % 252 + 4) : 8'(m);
            wr(0, {24'h0, c});
            @(posedge clock);
            chk(33'({t_rand, t_pre, t_car}), 33'({c == 1, c == 2, c == 3}));
        end
        for (int n = 0; n < 18; n++) begin
            c = (n < 9) ? 8'hA0 + 8'(n) : codes[n - 9];
            src <= 13'($urandom);
            wr(9, {24'h0, c});
            @(posedge clock);
            e = pins(c);
            chk(33'({gp0, gp1, gp2, girq, gp5, sport_en}), 33'(e));
            if (e[0]) chk(33'(smode), 33'(c - `RVT_PF_SPORT_FIRST));
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
